// ==== hsc_pulse_counter.sv ====
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - six BCD digits, counts up and down
// - three input modes picked by switch
// - quadrature: input 1 leading counts up
// - rate limits 50K, 20K, 30 cps
// - coincidence and above outputs driven
// - activity lamp lit while input 1 low
// - up and down lamps show direction
// - above, equal, below lamps from compare
// - equal lamp off without output enable
// - command mode 1 direction from program
// - command mode 2 direction from input 2
// - contact setting forces mode 1, 30 cps
// - solid-state setting allows all modes, fast
// - sticky carry and borrow on wrap
// - coincidence holds until reset or pin
// - counts only while gate command on
// - mode 1 counts input 1 rising edges
module hsc_pulse_counter
    import hsc_pkg::*;
#(
    parameter int CONTACT_FILTER_CYCLES = HSC_CONTACT_FILTER_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic count_in1,
    input wire logic count_in2,
    input wire logic ext_reset_in,
    input wire logic [1:0] mode_switch,
    input wire logic contact_select,
    output logic coincidence_out,
    output logic count_above_setpoint_out,
    output logic count_activity_indicator,
    output logic up_indicator,
    output logic down_indicator,
    output logic count_above_setpoint_indicator,
    output logic count_equals_setpoint_indicator,
    output logic count_below_setpoint_indicator
);
    localparam int FILT_W = $clog2(CONTACT_FILTER_CYCLES + 1);
    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(CONTACT_FILTER_CYCLES - 1);

    hsc_count_if cif ();

    hsc_bcd_counter u_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .cnt(cif.counter)
    );

    // bus slave state
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic [15:0] cmd_word;
    logic [15:0] preset_hi;

    // pin synchronisers
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic [1:0] mode_s;
    logic in1_s;
    logic in2_s;
    logic ext_rst_s;
    logic contact_s;
    logic sync_contact;

    // count path
    logic in1_filt;
    logic in1_prev;
    logic [FILT_W-1:0] filt_cnt;
    hsc_mode_t mode_eff;
    logic rise1;
    logic next_down;
    logic dir_down;

    // values and flags
    logic [HSC_BCD_W-1:0] setpoint;
    logic [HSC_BCD_W-1:0] preset_value;
    logic step_d;
    logic carry_flag;
    logic borrow_flag;
    logic coin_flag;
    logic above;
    logic equal;
    logic below;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // pins from outside the clock domain: two flops each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= {contact_select, mode_switch, ext_reset_in, count_in2, count_in1};
            sync_b <= sync_a;
        end
    end

    assign in1_s = sync_b[0];
    assign in2_s = sync_b[1];
    assign ext_rst_s = sync_b[2];
    assign mode_s = sync_b[4:3];
    assign contact_s = sync_b[5];

    assign preset_value = {preset_hi, cmd_word[15:HSC_CMD_PRESET_LO]};

    // contact setting locks out modes 2 and phase
    always_comb begin
        case (mode_s)
            2'b00: mode_eff = HSC_MODE_CMD1;
            2'b01: mode_eff = HSC_MODE_CMD2;
            2'b10: mode_eff = HSC_MODE_PHASE;
            default: mode_eff = HSC_MODE_CMD1;
        endcase
        if (sync_contact) begin
            mode_eff = HSC_MODE_CMD1;
        end
    end

    // contact bounce is removed by a stable-time filter; the solid-state
    // path passes straight through so 50K cps edges are never swallowed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in1_filt <= 1'b0;
            filt_cnt <= '0;
        end else if (!sync_contact) begin
            in1_filt <= in1_s;
            filt_cnt <= '0;
        end else if (in1_s == in1_filt) begin
            filt_cnt <= '0;
        end else if (filt_cnt >= FILT_LAST) begin
            in1_filt <= in1_s;
            filt_cnt <= '0;
        end else begin
            filt_cnt <= filt_cnt + FILT_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in1_prev <= 1'b0;
        end else begin
            in1_prev <= in1_filt;
        end
    end

    assign rise1 = in1_filt && !in1_prev;

    // direction for the present step
    always_comb begin
        case (mode_eff)
            HSC_MODE_CMD1: next_down = cmd_word[HSC_CMD_DOWN];
            HSC_MODE_CMD2: next_down = !in2_s;
            // input 2 still low at input 1's rise means input 1 leads
            HSC_MODE_PHASE: next_down = rise1 ? in2_s : dir_down;
            default: next_down = cmd_word[HSC_CMD_DOWN];
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_down <= 1'b0;
        end else begin
            dir_down <= next_down;
        end
    end

    // input 2 plays no part in mode 1; the source keeps within its rate
    assign cif.step = rise1 && cmd_word[HSC_CMD_GATE];
    assign cif.down = next_down;
    assign cif.load = cmd_word[HSC_CMD_COUNTER_PRESET];
    assign cif.load_value = preset_value;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            setpoint <= HSC_BCD_ZERO;
        end else if (cmd_word[HSC_CMD_SETPOINT_PRESET]) begin
            setpoint <= preset_value;
        end
    end

    // packed BCD orders the same as its value
    assign above = cif.count > setpoint;
    assign equal = cif.count == setpoint;
    assign below = cif.count < setpoint;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_d <= 1'b0;
        end else begin
            step_d <= cif.step && !cif.load;
        end
    end

    // wrap sets win over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            carry_flag <= 1'b0;
            borrow_flag <= 1'b0;
        end else begin
            if (cif.carry_pulse) begin
                carry_flag <= 1'b1;
            end else if (cmd_word[HSC_CMD_CARRY_CLR] || ext_rst_s) begin
                carry_flag <= 1'b0;
            end
            if (cif.borrow_pulse) begin
                borrow_flag <= 1'b1;
            end else if (cmd_word[HSC_CMD_BORROW_CLR] || ext_rst_s) begin
                borrow_flag <= 1'b0;
            end
        end
    end

    // a held coincidence reset keeps the flag off even on a match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coin_flag <= 1'b0;
        end else if (cmd_word[HSC_CMD_COIN_CLR] || ext_rst_s) begin
            coin_flag <= 1'b0;
        end else if (step_d && equal) begin
            coin_flag <= 1'b1;
        end
    end

    // outputs and lamps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coincidence_out <= 1'b0;
            count_above_setpoint_out <= 1'b0;
            count_activity_indicator <= 1'b0;
            up_indicator <= 1'b0;
            down_indicator <= 1'b0;
            count_above_setpoint_indicator <= 1'b0;
            count_equals_setpoint_indicator <= 1'b0;
            count_below_setpoint_indicator <= 1'b0;
        end else begin
            coincidence_out <= coin_flag && cmd_word[HSC_CMD_OUT_EN];
            count_above_setpoint_out <= above && cmd_word[HSC_CMD_OUT_EN];
            count_activity_indicator <= !in1_s;
            up_indicator <= !dir_down;
            down_indicator <= dir_down;
            count_above_setpoint_indicator <= above;
            count_equals_setpoint_indicator <= equal && cmd_word[HSC_CMD_OUT_EN];
            count_below_setpoint_indicator <= below;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_ofs <= 8'h00;
        end else begin
            wr_pend <= hsel && htrans[1] && hwrite && hready;
            wr_ofs <= haddr[7:0];
        end
    end

    // command bits are levels: software sets and later clears them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_word <= HSC_CMD_RESET;
            preset_hi <= HSC_CMD_RESET;
        end else if (wr_pend && wr_ofs == HSC_CMD_OFS) begin
            cmd_word <= hwdata[15:0];
        end else if (wr_pend && wr_ofs == HSC_PRESET_HI_OFS) begin
            preset_hi <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && htrans[1] && !hwrite && hready) begin
            case (haddr[7:0])
                HSC_CMD_OFS: hrdata <= {16'h0000, cmd_word};
                HSC_PRESET_HI_OFS: hrdata <= {16'h0000, preset_hi};
                HSC_STATUS_OFS: hrdata <= {16'h0000, cif.count[7:0], HSC_ST_ALWAYS_ON,
                    below, coin_flag, above, borrow_flag, carry_flag};
                HSC_COUNT_HI_OFS: hrdata <= {16'h0000, cif.count[HSC_BCD_W-1:8]};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign sync_contact = contact_s;

endmodule : hsc_pulse_counter

// ==== hsc_pkg.sv ====
package hsc_pkg;

    // register byte offsets, one word per register
    localparam logic [7:0] HSC_CMD_OFS = 8'h00;
    localparam logic [7:0] HSC_PRESET_HI_OFS = 8'h04;
    localparam logic [7:0] HSC_STATUS_OFS = 8'h08;
    localparam logic [7:0] HSC_COUNT_HI_OFS = 8'h0C;

    // command word fields
    localparam int HSC_CMD_COUNTER_PRESET = 0;
    localparam int HSC_CMD_SETPOINT_PRESET = 1;
    localparam int HSC_CMD_GATE = 2;
    localparam int HSC_CMD_DOWN = 3;
    localparam int HSC_CMD_CARRY_CLR = 4;
    localparam int HSC_CMD_BORROW_CLR = 5;
    localparam int HSC_CMD_COIN_CLR = 6;
    localparam int HSC_CMD_OUT_EN = 7;
    localparam int HSC_CMD_PRESET_LO = 8;

    // status word fields
    localparam int HSC_ST_CARRY = 0;
    localparam int HSC_ST_BORROW = 1;
    localparam int HSC_ST_ABOVE = 2;
    localparam int HSC_ST_EQUAL = 3;
    localparam int HSC_ST_BELOW = 4;
    localparam int HSC_ST_COUNT_LO = 8;
    localparam logic [2:0] HSC_ST_ALWAYS_ON = 3'h7;

    localparam int HSC_DIGITS = 6;
    localparam int HSC_BCD_W = 4 * HSC_DIGITS;
    localparam logic [15:0] HSC_CMD_RESET = 16'h0000;
    localparam logic [HSC_BCD_W-1:0] HSC_BCD_ZERO = 24'h00_0000;
    localparam logic [3:0] HSC_DIGIT_MAX = 4'h9;
    localparam logic [3:0] HSC_DIGIT_MIN = 4'h0;

    // contact input response: 30 cps, filtered by a stable time
    localparam int HSC_CLK_PERIOD_NS = 4;
    localparam int HSC_CONTACT_FILTER_NS = 10_000_000;
    localparam int HSC_CONTACT_FILTER_CYCLES = HSC_CONTACT_FILTER_NS / HSC_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        HSC_MODE_CMD1 = 2'b00,
        HSC_MODE_CMD2 = 2'b01,
        HSC_MODE_PHASE = 2'b10
    } hsc_mode_t;

endpackage : hsc_pkg

// ==== hsc_count_if.sv ====
`timescale 1ns/1ps
interface hsc_count_if;
    import hsc_pkg::*;
    logic step;
    logic down;
    logic load;
    logic [HSC_BCD_W-1:0] load_value;
    logic [HSC_BCD_W-1:0] count;
    logic carry_pulse;
    logic borrow_pulse;

    modport ctrl (output step, output down, output load, output load_value,
                  input count, input carry_pulse, input borrow_pulse);
    modport counter (input step, input down, input load, input load_value,
                     output count, output carry_pulse, output borrow_pulse);
endinterface : hsc_count_if

// ==== hsc_bcd_counter.sv ====
`timescale 1ns/1ps
module hsc_bcd_counter
    import hsc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    hsc_count_if.counter cnt
);
    logic [3:0] digit [HSC_DIGITS];
    logic [HSC_DIGITS:0] roll_up;
    logic [HSC_DIGITS:0] roll_dn;

    assign roll_up[0] = 1'b1;
    assign roll_dn[0] = 1'b1;

    // one digit per loop pass; a digit moves only when all lower digits roll
    for (genvar i = 0; i < HSC_DIGITS; i++) begin : g_digit
        assign roll_up[i+1] = roll_up[i] && (digit[i] == HSC_DIGIT_MAX);
        assign roll_dn[i+1] = roll_dn[i] && (digit[i] == HSC_DIGIT_MIN);
        assign cnt.count[4*i +: 4] = digit[i];

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                digit[i] <= HSC_DIGIT_MIN;
            end else if (cnt.load) begin
                digit[i] <= cnt.load_value[4*i +: 4];
            end else if (cnt.step && !cnt.down && roll_up[i]) begin
                digit[i] <= (digit[i] >= HSC_DIGIT_MAX) ? HSC_DIGIT_MIN : digit[i] + 4'h1;
            end else if (cnt.step && cnt.down && roll_dn[i]) begin
                digit[i] <= (digit[i] == HSC_DIGIT_MIN) ? HSC_DIGIT_MAX : digit[i] - 4'h1;
            end
        end
    end

    // wrap pulses, one cycle after the step that wrapped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt.carry_pulse <= 1'b0;
            cnt.borrow_pulse <= 1'b0;
        end else begin
            cnt.carry_pulse <= cnt.step && !cnt.load && !cnt.down && roll_up[HSC_DIGITS];
            cnt.borrow_pulse <= cnt.step && !cnt.load && cnt.down && roll_dn[HSC_DIGITS];
        end
    end

endmodule : hsc_bcd_counter

// ==== hsc_pulse_counter_props.sv ====
`timescale 1ns/1ps
module hsc_pulse_counter_props
    import hsc_pkg::*;
#(
    parameter int CONTACT_FILTER_CYCLES = HSC_CONTACT_FILTER_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic count_in1,
    input wire logic ext_reset_in,
    input wire logic coincidence_out,
    input wire logic count_above_setpoint_out,
    input wire logic count_activity_indicator,
    input wire logic up_indicator,
    input wire logic down_indicator,
    input wire logic count_above_setpoint_indicator,
    input wire logic count_equals_setpoint_indicator,
    input wire logic count_below_setpoint_indicator
);
    logic [3:0] quiet_cnt;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // cycles since the last bus request or external reset; saturates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_cnt <= 4'h0;
        end else if (ext_reset_in || htrans[1]) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hf) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end

    sequence rd_s(logic [7:0] ofs);
        hsel && htrans[1] && hready && !hwrite && haddr == {24'h00_0000, ofs};
    endsequence

    status_fixed_a: assert property (rd_s(HSC_STATUS_OFS) |=>
        hrdata[7:5] == HSC_ST_ALWAYS_ON && hrdata[31:16] == 16'h0000)
        else $error("status fixed bits wrong");
    activity_lit_a: assert property (!count_in1 [*5] |-> count_activity_indicator)
        else $error("activity lamp dark while input low");
    activity_dark_a: assert property (count_in1 [*5] |-> !count_activity_indicator)
        else $error("activity lamp lit while input high");
    direction_lamp_a: assert property ($past(hresetn) |-> up_indicator != down_indicator)
        else $error("up and down lamps not exclusive");
    compare_excl_a: assert property (!(count_above_setpoint_indicator
        && count_below_setpoint_indicator)) else $error("above and below both lit");
    equal_alone_a: assert property (count_equals_setpoint_indicator |->
        !count_above_setpoint_indicator && !count_below_setpoint_indicator)
        else $error("equal lamp lit with above or below");
    above_out_a: assert property (count_above_setpoint_out |->
        count_above_setpoint_indicator) else $error("above output without compare");
    coin_cleared_a: assert property (ext_reset_in [*5] |-> !coincidence_out)
        else $error("coincidence held through external reset");
    coin_hold_a: assert property ($fell(coincidence_out) |-> quiet_cnt < 4'h6)
        else $error("coincidence dropped without cause");
endmodule : hsc_pulse_counter_props

// ==== hsc_pulse_src.sv ====
`timescale 1ns/1ps
module hsc_pulse_src (
    input wire logic hclk,
    output logic count_in1,
    output logic count_in2
);
    initial begin
        count_in1 = 1'b0;
        count_in2 = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask : step

    // in2 settles before the in1 edge so the direction level is never racing it
    task automatic pulse(input logic lvl2, input int half);
        count_in2 <= lvl2;
        step(4);
        count_in1 <= 1'b1;
        step(half);
        count_in1 <= 1'b0;
        step(half);
    endtask : pulse

    // quarter period spacing; up when in1 leads in2
    task automatic quad(input logic up, input int q);
        {count_in1, count_in2} <= up ? 2'b10 : 2'b01;
        step(q);
        {count_in1, count_in2} <= 2'b11;
        step(q);
        {count_in1, count_in2} <= up ? 2'b01 : 2'b10;
        step(q);
        {count_in1, count_in2} <= 2'b00;
        step(q);
    endtask : quad
endmodule : hsc_pulse_src

// ==== hsc_pulse_counter_bench.sv ====
`timescale 1ns/1ps
module hsc_pulse_counter_bench;
    import hsc_pkg::*;
    localparam int FILT_CYCLES = 8;
    // half and quarter periods keep the solid-state and quadrature rates within the rated limits; contact pulses run far above 30 cps
    localparam int SOLID_HALF = 2500;
    localparam int PHASE_Q = 3125;
    localparam int CONTACT_HALF = 2 * FILT_CYCLES;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, count_in1, count_in2, coincidence_out, count_above_setpoint_out;
    logic count_activity_indicator, up_indicator, down_indicator;
    logic count_above_setpoint_indicator, count_equals_setpoint_indicator;
    logic count_below_setpoint_indicator;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic ext_reset_in = 1'b0;
    logic [1:0] mode_switch = 2'h0;
    logic contact_select = 1'b0;
    logic [15:0] cmd = 16'h0000;
    int err_count = 0;
    int n_tests = 0;

    always #2 hclk = ~hclk;

    hsc_pulse_counter #(.CONTACT_FILTER_CYCLES(FILT_CYCLES)) hsc_pulse_counter_inst (
        .hsel(1'b1), .hsize(3'h2), .hready(hreadyout), .*);
    hsc_pulse_src hsc_pulse_src_inst (.hclk(hclk), .count_in1(count_in1),
        .count_in2(count_in2));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : cyc

    task automatic setcmd(input logic [15:0] c);
        cmd = c;
        cyc(HSC_CMD_OFS, 1'b1, {16'h0000, c});
    endtask : setcmd

    task automatic preset(input logic [23:0] v, input int bitn);
        cyc(HSC_PRESET_HI_OFS, 1'b1, {16'h0000, v[23:8]});
        cyc(HSC_CMD_OFS, 1'b1, {16'h0000, v[7:0], cmd[7:0] | (8'h01 << bitn)});
        cyc(HSC_CMD_OFS, 1'b1, {16'h0000, cmd});
    endtask : preset

    task automatic st(input logic [7:0] lo, input logic [4:0] fl);
        cyc(HSC_STATUS_OFS, 1'b0, 32'h0000_0000);
        check(rd, {16'h0000, lo, HSC_ST_ALWAYS_ON, fl});
    endtask : st

    task automatic final_report();
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (95_000) @(posedge hclk);
        err_count++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        st(8'h00, 5'h00);
        cyc(HSC_COUNT_HI_OFS, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        cyc(8'h10, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(32'({hresp, hreadyout, count_above_setpoint_indicator,
            count_below_setpoint_indicator, up_indicator, down_indicator,
            count_equals_setpoint_indicator, count_activity_indicator}),
            32'h0000_0049);
        preset(24'h00_0012, HSC_CMD_SETPOINT_PRESET);
        preset(24'h00_0010, HSC_CMD_COUNTER_PRESET);
        setcmd(16'h0084);
        st(8'h10, 5'h10);
        check(32'({count_above_setpoint_indicator, count_below_setpoint_indicator}),
            32'h0000_0001);
        hsc_pulse_src_inst.pulse(1'b1, SOLID_HALF);
        hsc_pulse_src_inst.pulse(1'b0, SOLID_HALF);
        st(8'h12, 5'h08);
        check(32'({coincidence_out, count_equals_setpoint_indicator,
            count_above_setpoint_out}), 32'h0000_0006);
        setcmd(16'h0004);
        st(8'h12, 5'h08);
        check(32'({coincidence_out, count_equals_setpoint_indicator}), 32'h0000_0000);
        setcmd(16'h0084);
        ext_reset_in <= 1'b1;
        repeat (8) @(posedge hclk);
        ext_reset_in <= 1'b0;
        st(8'h12, 5'h00);
        check(32'({coincidence_out, count_equals_setpoint_indicator}), 32'h0000_0001);
        setcmd(16'h0080);
        hsc_pulse_src_inst.pulse(1'b0, SOLID_HALF);
        st(8'h12, 5'h00);
        setcmd(16'h008c);
        hsc_pulse_src_inst.pulse(1'b0, SOLID_HALF);
        st(8'h11, 5'h10);
        check(32'({up_indicator, down_indicator}), 32'h0000_0001);
        preset(24'h00_0000, HSC_CMD_COUNTER_PRESET);
        hsc_pulse_src_inst.pulse(1'b0, SOLID_HALF);
        st(8'h99, 5'h06);
        check(32'({count_above_setpoint_out, count_above_setpoint_indicator}),
            32'h0000_0003);
        cyc(HSC_COUNT_HI_OFS, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_9999);
        setcmd(16'h0084);
        hsc_pulse_src_inst.pulse(1'b0, SOLID_HALF);
        st(8'h00, 5'h13);
        setcmd(16'h00a4);
        setcmd(16'h008c);
        st(8'h00, 5'h11);
        mode_switch <= 2'h1;
        hsc_pulse_src_inst.pulse(1'b1, SOLID_HALF);
        st(8'h01, 5'h11);
        hsc_pulse_src_inst.pulse(1'b0, SOLID_HALF);
        st(8'h00, 5'h11);
        mode_switch <= 2'h2;
        hsc_pulse_src_inst.quad(1'b1, PHASE_Q);
        st(8'h01, 5'h11);
        hsc_pulse_src_inst.quad(1'b0, PHASE_Q);
        st(8'h00, 5'h11);
        contact_select <= 1'b1;
        mode_switch <= 2'h1;
        setcmd(16'h0084);
        hsc_pulse_src_inst.pulse(1'b0, CONTACT_HALF);
        st(8'h01, 5'h11);
        preset(24'h00_0002, HSC_CMD_SETPOINT_PRESET);
        hsc_pulse_src_inst.pulse(1'b0, CONTACT_HALF);
        st(8'h02, 5'h09);
        setcmd(16'h00d4);
        setcmd(16'h0084);
        st(8'h02, 5'h00);
        final_report();
    end
endmodule : hsc_pulse_counter_bench

bind hsc_pulse_counter hsc_pulse_counter_props #(.CONTACT_FILTER_CYCLES(CONTACT_FILTER_CYCLES))
    hsc_pulse_counter_props_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hrdata, .count_in1, .ext_reset_in, .coincidence_out, .count_above_setpoint_out,
    .count_activity_indicator, .up_indicator, .down_indicator,
    .count_above_setpoint_indicator, .count_equals_setpoint_indicator,
    .count_below_setpoint_indicator);
